// File: rtl/ibsc_top.sv
// ibsc_top: two-wire bus sequence controller, register side and pins
// assumes: core_clk and linkClk are unrelated; pins are open drain with
// pull-ups outside; a register master that never waits
//
// Overview of operation
// R1: slave with stretch enabled holds clock low on release bit clear or byte receive.
// R2: acknowledge sequence drives the acknowledge data bit; 1 is NACK, 0 is ACK.
// R3: acknowledge request runs the ack sequence, cleared by hardware when done.
// R4: receive request clocks in one byte, cleared after the eighth bit.
// R5: stop request makes a Stop condition, cleared by hardware when done.
// R6: repeated start request makes a Repeated Start, cleared by hardware when done.
// R7: start request makes a Start condition, cleared by hardware when done.
// R8: software keeps peripheral management enable at 0 for master work.
// R9: one master sequence at a time; new requests while busy are ignored.

`timescale 1ns/10ps
`default_nettype none

module ibsc_top (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic linkClk,
	input wire logic [ibsc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [ibsc_pkg::DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [ibsc_pkg::DATA_W-1:0] regRdData,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOeN,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOeN
);
	import ibsc_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------

	// one request per write; lower bits win when several are written
	function automatic ibsc_seq_t pickSeq(logic [15:0] w);
		if (w[START_BIT]) pickSeq = SEQ_START;
		else if (w[RSTART_BIT]) pickSeq = SEQ_RSTART;
		else if (w[STOP_BIT]) pickSeq = SEQ_STOP;
		else if (w[RECV_BIT]) pickSeq = SEQ_RECV;
		else if (w[ACKSEQ_BIT]) pickSeq = SEQ_ACK;
		else pickSeq = SEQ_NONE;
	endfunction

	function automatic logic [15:0] seqMask(ibsc_seq_t s);
		seqMask = 16'h0000;
		unique case (s)
			SEQ_START: seqMask[START_BIT] = 1'b1;
			SEQ_RSTART: seqMask[RSTART_BIT] = 1'b1;
			SEQ_STOP: seqMask[STOP_BIT] = 1'b1;
			SEQ_RECV: seqMask[RECV_BIT] = 1'b1;
			SEQ_ACK: seqMask[ACKSEQ_BIT] = 1'b1;
			default: seqMask = 16'h0000;
		endcase
	endfunction

	ibsc_link_if lnk ();

	// ----------------------------------------------------------------
	// register clock domain
	// ----------------------------------------------------------------
	logic [15:0] ctrl, next_ctrl;
	logic busy, next_busy;
	ibsc_seq_t reqCode, next_reqCode;
	logic reqToggle, next_reqToggle;
	logic ackHold, next_ackHold;
	logic [7:0] rxByte, next_rxByte;
	logic [15:0] next_rdData;
	logic doneMeta, doneSync, doneSeen;
	logic evtMeta, evtSync, evtSeen;
	logic strMeta, strSync;
	// link-side state that the crossings below read
	logic holdActive, next_holdActive;
	logic evtToggle, next_evtToggle;
	logic doneEvt, rxEvt, masterOn;
	logic [15:0] statusWord;
	ibsc_seq_t pick;

	// ----------------------------------------------------------------
	// crossings from the link clock domain
	// ----------------------------------------------------------------

	// sequence end arrives as a toggle; only the second and third flops feed logic
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			doneMeta <= 1'b0;
			doneSync <= 1'b0;
			doneSeen <= 1'b0;
		end else begin
			doneMeta <= lnk.doneToggle;
			doneSync <= doneMeta;
			doneSeen <= doneSync;
		end
	end

	// slave byte received, also a toggle, so no short pulse is missed
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			evtMeta <= 1'b0;
			evtSync <= 1'b0;
			evtSeen <= 1'b0;
		end else begin
			evtMeta <= evtToggle;
			evtSync <= evtMeta;
			evtSeen <= evtSync;
		end
	end

	// stretch status is a slow level, shown only in the status word
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			strMeta <= 1'b0;
			strSync <= 1'b0;
		end else begin
			strMeta <= holdActive;
			strSync <= strMeta;
		end
	end

	assign doneEvt = doneSync ^ doneSeen;
	assign rxEvt = evtSync ^ evtSeen;
	// the write's own mode bits decide, so enable and launch may share one write
	assign masterOn = regWrData[ENABLE_BIT] && !regWrData[SLAVE_BIT];

	// control register, request launch and read port
	always_comb begin
		next_ctrl = ctrl;
		next_busy = busy;
		next_reqCode = reqCode;
		next_reqToggle = reqToggle;
		next_ackHold = ackHold;
		next_rxByte = rxByte;
		next_rdData = '0;
		statusWord = '0;
		pick = pickSeq(regWrData);
		// sequence finished: request bits read 0 again
		if (doneEvt) begin
			next_ctrl = ctrl & ~REQ_MASK; // R3 R4 R5 R6 R7
			next_busy = 1'b0;
			if (reqCode == SEQ_RECV) begin
				next_rxByte = lnk.rxByte; // R4
			end
		end
		if (regWr && regAddr == CTRL_OFS) begin
			next_ctrl = (next_ctrl & ~WRITE_MASK) | (regWrData & WRITE_MASK);
			// busy covers the done cycle too, so a late request never overlaps
			if (pick != SEQ_NONE && !busy && masterOn) begin
				next_ctrl = next_ctrl | seqMask(pick); // R9
				next_busy = 1'b1;
				next_reqCode = pick;
				next_reqToggle = !reqToggle;
				next_ackHold = regWrData[ACKDATA_BIT]; // R2
			end
		end
		// receive stretch clears release; hardware beats a same-cycle write
		if (rxEvt) begin
			next_ctrl[RELEASE_BIT] = 1'b0; // R1
		end
		statusWord[STAT_BUSY_BIT] = busy;
		statusWord[STAT_STRETCH_BIT] = strSync;
		statusWord[STAT_RX_LSB +: 8] = rxByte;
		if (regRd) begin
			if (regAddr == CTRL_OFS) begin
				next_rdData = ctrl;
			end else if (regAddr == STAT_OFS) begin
				next_rdData = statusWord;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ctrl <= CTRL_RESET;
			busy <= 1'b0;
			reqCode <= SEQ_NONE;
			reqToggle <= 1'b0;
			ackHold <= 1'b0;
			rxByte <= 8'h00;
			regRdData <= '0;
		end else begin
			ctrl <= next_ctrl;
			busy <= next_busy;
			reqCode <= next_reqCode;
			reqToggle <= next_reqToggle;
			ackHold <= next_ackHold;
			rxByte <= next_rxByte;
			regRdData <= next_rdData;
		end
	end

	// held stable while busy, so the engine may sample them late
	assign lnk.reqToggle = reqToggle;
	assign lnk.reqCode = reqCode;
	assign lnk.ackValue = ackHold;

	// ----------------------------------------------------------------
	// link clock domain
	// ----------------------------------------------------------------
	logic rstMeta, linkRstN;
	logic sclMeta, sclSync, sclPrev;
	logic sdaMeta, sdaSync, sdaPrev;
	logic [2:0] cfgMeta, cfgSync;
	logic [3:0] slvCnt, next_slvCnt;
	logic rxHold, next_rxHold;
	logic next_sclOeN, next_sdaOeN;
	logic slaveOn, stretchOn, released, holdCond;
	logic sclRise, sclFall, startCond, stopCond;

	// reset reaches the link side through two flops
	always_ff @(posedge linkClk) begin
		rstMeta <= resetn;
		linkRstN <= rstMeta;
	end

	// pins are asynchronous; the third flop only feeds the edge detectors
	always_ff @(posedge linkClk) begin
		sclMeta <= sclIn;
		sclSync <= sclMeta;
		sclPrev <= sclSync;
		sdaMeta <= sdaIn;
		sdaSync <= sdaMeta;
		sdaPrev <= sdaSync;
	end

	// independent control levels; a one-cycle skew between them is harmless
	always_ff @(posedge linkClk) begin
		cfgMeta <= {ctrl[RELEASE_BIT], ctrl[STRETCH_BIT],
			ctrl[ENABLE_BIT] & ctrl[SLAVE_BIT]};
		cfgSync <= cfgMeta;
	end

	assign lnk.linkRstN = linkRstN;
	assign lnk.sclIn = sclSync;
	assign lnk.sdaIn = sdaSync;
	assign slaveOn = cfgSync[0];
	assign stretchOn = cfgSync[1];
	assign released = cfgSync[2];
	assign sclRise = sclSync && !sclPrev;
	assign sclFall = !sclSync && sclPrev;
	assign startCond = sclSync && sclPrev && sdaPrev && !sdaSync;
	assign stopCond = sclSync && sclPrev && !sdaPrev && sdaSync;
	assign holdCond = slaveOn && stretchOn && (rxHold || !released); // R1

	// ----------------------------------------------------------------
	// slave clock stretching
	// ----------------------------------------------------------------

	// slave bit counting and clock stretching
	always_comb begin
		next_slvCnt = slvCnt;
		next_rxHold = rxHold;
		next_evtToggle = evtToggle;
		if (startCond || stopCond || !slaveOn) begin
			next_slvCnt = 4'h0;
		end else if (sclRise) begin
			next_slvCnt = (slvCnt == SLAVE_FRAME_BITS) ? 4'h1 : slvCnt + 4'h1;
		end
		// byte received: stretch before the acknowledge bit
		if (sclFall && slaveOn && stretchOn && slvCnt == SLAVE_DATA_BITS) begin
			next_rxHold = 1'b1; // R1
			next_evtToggle = !evtToggle;
		end else if (!released || !stretchOn) begin
			// release bit now holds the line, or stretching is off
			next_rxHold = 1'b0;
		end
		// only stretch a low clock, never cut a high phase short
		next_holdActive = holdCond && (holdActive || !sclSync); // R1
		next_sclOeN = !(lnk.sclLow || holdActive);
		next_sdaOeN = !lnk.sdaLow;
	end

	always_ff @(posedge linkClk) begin
		if (!linkRstN) begin
			slvCnt <= 4'h0;
			rxHold <= 1'b0;
			holdActive <= 1'b0;
			evtToggle <= 1'b0;
			sclOeN <= 1'b1;
			sdaOeN <= 1'b1;
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
		end else begin
			slvCnt <= next_slvCnt;
			rxHold <= next_rxHold;
			holdActive <= next_holdActive;
			evtToggle <= next_evtToggle;
			sclOeN <= next_sclOeN;
			sdaOeN <= next_sdaOeN;
			sclOut <= 1'b0;
			sdaOut <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// master sequence engine
	// ----------------------------------------------------------------
	ibsc_master_seq u_seq (
		.linkClk(linkClk),
		.lnk(lnk)
	);
endmodule

`default_nettype wire

// File: rtl/ibsc_pkg.sv
// ibsc_pkg: constants and types shared by the bus sequence controller files
// assumes: a 16-bit register port and a free running link clock

package ibsc_pkg;

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h1;

	// control register fields
	localparam int START_BIT = 0;
	localparam int RSTART_BIT = 1;
	localparam int STOP_BIT = 2;
	localparam int RECV_BIT = 3;
	localparam int ACKSEQ_BIT = 4;
	localparam int ACKDATA_BIT = 5;
	localparam int STRETCH_BIT = 6;
	localparam int SLAVE_BIT = 8;
	localparam int PMGMT_BIT = 11;
	localparam int RELEASE_BIT = 12;
	localparam int ENABLE_BIT = 15;
	localparam logic [15:0] CTRL_RESET = 16'h1000;
	localparam logic [15:0] REQ_MASK = 16'h001F;
	localparam logic [15:0] WRITE_MASK = 16'h9960;

	// status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_STRETCH_BIT = 1;
	localparam int STAT_RX_LSB = 8;

	// ----------------------------------------------------------------
	// link timing: link clock cycles per quarter of a bus bit
	// ----------------------------------------------------------------
	localparam logic [7:0] QUARTER_TICKS = 8'h19;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [3:0] SLAVE_DATA_BITS = 4'h8;
	localparam logic [3:0] SLAVE_FRAME_BITS = 4'h9;

	typedef enum logic [2:0] {
		SEQ_NONE = 3'b000,
		SEQ_START = 3'b001,
		SEQ_RSTART = 3'b010,
		SEQ_STOP = 3'b011,
		SEQ_RECV = 3'b100,
		SEQ_ACK = 3'b101
	} ibsc_seq_t;

	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00,
		ENG_RUN = 2'b01
	} ibsc_eng_t;

endpackage

// File: rtl/ibsc_link_if.sv
// ibsc_link_if: carries requests, results and line levels between the
// register side and the master sequence engine
// assumes: every signal has a single driver on one side of the modports

`timescale 1ns/10ps
`default_nettype none

interface ibsc_link_if;
	logic linkRstN;
	logic sclIn;
	logic sdaIn;
	logic reqToggle;
	ibsc_pkg::ibsc_seq_t reqCode;
	logic ackValue;
	logic doneToggle;
	logic [7:0] rxByte;
	logic sclLow;
	logic sdaLow;

	modport ctl (output linkRstN, sclIn, sdaIn, reqToggle, reqCode, ackValue,
		input doneToggle, rxByte, sclLow, sdaLow);
	modport eng (input linkRstN, sclIn, sdaIn, reqToggle, reqCode, ackValue,
		output doneToggle, rxByte, sclLow, sdaLow);
endinterface

`default_nettype wire

// File: rtl/ibsc_master_seq.sv
// ibsc_master_seq: bus master sequence engine on the link clock
// assumes: reqCode and ackValue stand still from before a request toggle
// until the matching done toggle; pin levels arrive already synchronised

`timescale 1ns/10ps
`default_nettype none

module ibsc_master_seq (
	input wire logic linkClk,
	ibsc_link_if.eng lnk
);
	import ibsc_pkg::*;

	// ----------------------------------------------------------------
	// line levels per quarter phase, as {scl high, sda high}
	// ----------------------------------------------------------------
	function automatic logic [1:0] lineLevels(ibsc_seq_t s, logic [1:0] ph, logic ackv);
		logic mid;
		mid = (ph == 2'h1) || (ph == 2'h2);
		unique case (s)
			SEQ_START: lineLevels = {ph < 2'h2, ph == 2'h0};
			SEQ_RSTART: lineLevels = {mid, ph < 2'h2};
			SEQ_STOP: lineLevels = {ph != 2'h0, ph >= 2'h2};
			SEQ_RECV: lineLevels = {mid, 1'b1};
			SEQ_ACK: lineLevels = {mid, ackv};
			default: lineLevels = 2'h3;
		endcase
	endfunction

	ibsc_eng_t state, next_state;
	ibsc_seq_t seq, next_seq;
	logic [1:0] phase, next_phase;
	logic [7:0] tick, next_tick;
	logic [2:0] bitCnt, next_bitCnt;
	logic [7:0] rxShift, next_rxShift;
	logic sclLow, next_sclLow;
	logic sdaLow, next_sdaLow;
	logic doneToggle, next_doneToggle;
	logic reqSeen, next_reqSeen;
	logic reqMeta, reqSync;
	logic [1:0] levels;

	// request toggle crosses in from the register clock
	always_ff @(posedge linkClk) begin
		reqMeta <= lnk.reqToggle;
		reqSync <= reqMeta;
	end

	// ----------------------------------------------------------------
	// sequence state machine
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_seq = seq;
		next_phase = phase;
		next_tick = tick;
		next_bitCnt = bitCnt;
		next_rxShift = rxShift;
		next_sclLow = sclLow;
		next_sdaLow = sdaLow;
		next_doneToggle = doneToggle;
		next_reqSeen = reqSeen;
		levels = lineLevels(seq, phase, lnk.ackValue);
		unique case (state)
			ENG_IDLE: begin
				// lines keep their last level between sequences
				if (reqSync != reqSeen) begin
					next_reqSeen = reqSync;
					next_seq = lnk.reqCode;
					next_state = ENG_RUN;
					next_phase = 2'h0;
					next_tick = 8'h00;
					next_bitCnt = 3'h0;
				end
			end
			ENG_RUN: begin
				next_sclLow = !levels[1]; // R5 R6 R7
				next_sdaLow = !levels[0]; // R2
				if (levels[1] && !sclLow && !lnk.sclIn) begin
					// a slave holds the clock low: wait, do not lose the quarter
					next_tick = tick;
				end else if (tick != QUARTER_TICKS - 8'h01) begin
					next_tick = tick + 8'h01;
				end else begin
					next_tick = 8'h00;
					next_phase = phase + 2'h1;
					if (seq == SEQ_RECV && phase == 2'h2) begin
						next_rxShift = {rxShift[6:0], lnk.sdaIn}; // R4
					end
					if (phase == 2'h3) begin
						if (seq == SEQ_RECV && bitCnt != LAST_BIT) begin
							next_bitCnt = bitCnt + 3'h1; // R4
						end else begin
							next_state = ENG_IDLE;
							next_doneToggle = !doneToggle; // R3 R4 R5 R6 R7
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge linkClk) begin
		if (!lnk.linkRstN) begin
			state <= ENG_IDLE;
			seq <= SEQ_NONE;
			phase <= 2'h0;
			tick <= 8'h00;
			bitCnt <= 3'h0;
			rxShift <= 8'h00;
			sclLow <= 1'b0;
			sdaLow <= 1'b0;
			doneToggle <= 1'b0;
			reqSeen <= 1'b0;
		end else begin
			state <= next_state;
			seq <= next_seq;
			phase <= next_phase;
			tick <= next_tick;
			bitCnt <= next_bitCnt;
			rxShift <= next_rxShift;
			sclLow <= next_sclLow;
			sdaLow <= next_sdaLow;
			doneToggle <= next_doneToggle;
			reqSeen <= next_reqSeen;
		end
	end

	assign lnk.sclLow = sclLow;
	assign lnk.sdaLow = sdaLow;
	assign lnk.doneToggle = doneToggle;
	assign lnk.rxByte = rxShift;
endmodule

`default_nettype wire

// File: test/ibsc_peer.sv
// ibsc_peer: behavioural device on the far side of the two-wire bus
// assumes: the bench resolves both lines as open drain with pull-ups
`timescale 1ns/10ps
`default_nettype none

module ibsc_peer (
	input wire logic linkClk,
	input wire logic sclLine,
	output logic sclPull,
	output logic sdaPull
);
	logic [7:0] txByte = 8'h00;
	int txLeft = 0;
	int holdLeft = 0;
	logic stretchArm = 1'b0;
	initial begin
		sclPull = 1'b0;
		sdaPull = 1'b0;
	end
	// ------------------------------------------------------------
	// slave role
	// ------------------------------------------------------------
	// byte for a master receive: msb first, next bit at each falling clock
	task automatic load(input logic [7:0] b);
		txByte = b;
		sdaPull = !b[7];
		txLeft = 8;
	endtask
	always @(negedge sclLine) begin
		if (txLeft > 1) begin
			txByte = txByte << 1;
			sdaPull = !txByte[7];
		end else if (txLeft == 1) begin
			sdaPull = 1'b0; // released, so the master can acknowledge
		end
		if (txLeft > 0) txLeft--;
		// a slow slave holds the clock low once, for 30 link cycles, ending inside the master's own low time
		if (stretchArm) begin
			sclPull = 1'b1;
			holdLeft = 30;
			stretchArm = 1'b0;
		end
	end
	always @(posedge linkClk) begin
		if (holdLeft == 1) sclPull = 1'b0;
		if (holdLeft > 0) holdLeft--;
	end
	// ------------------------------------------------------------
	// master role
	// ------------------------------------------------------------
	task automatic quarter();
		repeat (10) @(posedge linkClk);
	endtask
	// start and eight bits; the clock is let go after the ninth fall
	task automatic sendByte(input logic [7:0] b);
		sdaPull = 1'b1;
		quarter();
		for (int i = 7; i >= 0; i--) begin
			sclPull = 1'b1;
			sdaPull = !b[i];
			quarter();
			sclPull = 1'b0;
			quarter();
		end
		sclPull = 1'b1;
		sdaPull = 1'b0;
		quarter();
		sclPull = 1'b0;
	endtask
	task automatic stopBus();
		sclPull = 1'b1;
		quarter();
		sdaPull = 1'b1;
		quarter();
		sclPull = 1'b0;
		quarter();
		sdaPull = 1'b0;
		quarter();
	endtask
endmodule

`default_nettype wire

// File: test/ibsc_chk.sv
// ibsc_chk: register port and pin checks on ibsc_top, bound below
// assumes: every sequence, receive included, ends well inside the bound
`timescale 1ns/10ps
`default_nettype none

module ibsc_chk (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [ibsc_pkg::ADDR_W-1:0] regAddr,
	input wire logic [ibsc_pkg::DATA_W-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [ibsc_pkg::DATA_W-1:0] regRdData,
	input wire logic sclOut,
	input wire logic sclOeN,
	input wire logic sdaOut,
	input wire logic sdaOeN
);
	import ibsc_pkg::*;
	localparam int CLR_BOUND = 1500;
	int unsigned reqAge;
	int unsigned modeAge;
	logic anyReq;
	logic quietSlave;
	logic ctrlWr;
	logic ctrlRd;
	logic reqWr;
	logic idle;
	assign ctrlWr = regWr && regAddr == CTRL_OFS;
	assign ctrlRd = regRd && regAddr == CTRL_OFS;
	assign reqWr = ctrlWr && regWrData[ENABLE_BIT] && !regWrData[SLAVE_BIT]
		&& |(regWrData & REQ_MASK);
	// idle once the longest sequence has surely ended; a stretch adds little
	assign idle = !anyReq || reqAge > CLR_BOUND;
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			reqAge <= 0;
			modeAge <= 0;
			anyReq <= 1'b0;
			quietSlave <= 1'b0;
		end else begin
			reqAge <= reqWr ? 0 : (reqAge < 9999 ? reqAge + 1 : reqAge);
			modeAge <= ctrlWr ? 0 : (modeAge < 9999 ? modeAge + 1 : modeAge);
			anyReq <= anyReq || reqWr;
			if (ctrlWr) quietSlave <= regWrData[ENABLE_BIT] && regWrData[SLAVE_BIT]
				&& !regWrData[STRETCH_BIT];
		end
	end
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	a_read_quiet: assert property (!regRd |=> regRdData == 16'h0000)
		else $error("read data not zero outside a read answer");
	a_read_unmapped: assert property (regRd && regAddr > STAT_OFS |=> regRdData == 16'h0000)
		else $error("unmapped read not zero");
	a_ctrl_reserved: assert property (ctrlRd |=> (regRdData & 16'h6680) == 16'h0000)
		else $error("reserved control bits not zero");
	a_write_read: assert property (ctrlWr ##1 ctrlRd |=>
		(regRdData & 16'h8960) == ($past(regWrData, 2) & 16'h8960))
		else $error("stored control bits differ from write");
	a_launch_seen: assert property (reqWr && idle && regWrData[START_BIT] ##1 ctrlRd
		|=> regRdData[START_BIT])
		else $error("start request not shown after launch");
	a_req_cleared: assert property (ctrlRd && idle |=> regRdData[4:0] == 5'h00)
		else $error("request bit not cleared by hardware");
	a_lines_idle: assert property (!anyReq |-> sclOeN && sdaOeN)
		else $error("line pulled without any request");
	a_no_stretch: assert property (quietSlave && modeAge > 40 |-> sclOeN)
		else $error("clock held with stretching disabled");
	a_open_drain: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
		else $error("pin output level not low");
	c_receive: cover property (reqWr && regWrData[RECV_BIT]);
	c_quiet: cover property (quietSlave && modeAge > 40);
	c_unmapped: cover property (regRd && regAddr > STAT_OFS);
endmodule

bind ibsc_top ibsc_chk u_chk (.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
	.sclOut(sclOut), .sclOeN(sclOeN), .sdaOut(sdaOut), .sdaOeN(sdaOeN));

`default_nettype wire

// File: test/test_i2c_bus_sequence_control.sv
// test_i2c_bus_sequence_control: self-checking bench for ibsc_top
// assumes: package, design, peer model and checker compiled before it
`timescale 1ns/10ps
`default_nettype none

module test_i2c_bus_sequence_control;
	import ibsc_pkg::*;
	localparam logic [15:0] MASTER = 16'h9000;
	logic core_clk = 1'b0;
	logic linkClk = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWrData = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic rdSeen = 1'b0;
	logic [15:0] regRdData;
	logic [15:0] v;
	logic [31:0] note;
	logic [31:0] notes[$];
	logic [7:0] rxVal;
	logic sclOut;
	logic sclOeN;
	logic sdaOut;
	logic sdaOeN;
	logic sclPull;
	logic sdaPull;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	// open drain with pull-ups: low if any party pulls
	wire logic sclLine = sclOeN && !sclPull;
	wire logic sdaLine = sdaOeN && !sdaPull;
	always #2.5 core_clk = ~core_clk;
	initial begin
		#1.3;
		forever #3 linkClk = ~linkClk;
	end
	ibsc_top dut (.core_clk(core_clk), .resetn(resetn), .linkClk(linkClk), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.sclIn(sclLine), .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sdaLine),
		.sdaOut(sdaOut), .sdaOeN(sdaOeN));
	ibsc_peer peer (.linkClk(linkClk), .sclLine(sclLine), .sclPull(sclPull),
		.sdaPull(sdaPull));
	// ------------------------------------------------------------
	// checking and bus tasks
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons=%0d mismatches=%0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	function automatic logic [15:0] lines();
		return {14'h0000, sclLine, sdaLine};
	endfunction
	// bus tasks start and end right after a core_clk edge
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask
	// a zero mask turns the note into a poll that checks nothing
	task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
		notes.push_back({m, e});
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		@(posedge core_clk);
		v = regRdData;
	endtask
	task automatic waitIdle();
		v = 16'h0001;
		for (int k = 0; k < 3000 && v[0] !== 1'b0; k++) rd(STAT_OFS, 16'h0000, 16'h0000);
	endtask
	// launch, see the bit held, wait, see it gone and the lines it left
	task automatic seq(input logic [15:0] d, input logic [15:0] endLines);
		wr(CTRL_OFS, d);
		rd(CTRL_OFS, d, 16'hFFFF);
		waitIdle();
		rd(CTRL_OFS, d & ~REQ_MASK, 16'hFFFF);
		check(lines(), endLines);
	endtask
	// read answers are compared with the oldest note
	always @(posedge core_clk) begin
		cycles++;
		if (rdSeen) begin
			note = notes.pop_front();
			if (note[31:16] != 16'h0000) begin
				check(regRdData & note[31:16], note[15:0] & note[31:16]);
			end
		end
		rdSeen <= regRd;
		if (cycles == 40000) begin
			failures++;
			report_and_stop();
		end
	end
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		rxVal = 8'($urandom(46570));
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (8) @(posedge core_clk);
		rd(CTRL_OFS, CTRL_RESET, 16'hFFFF);
		wr(4'hF, 16'hFFFF);
		rd(4'hF, 16'h0000, 16'hFFFF);
		wr(CTRL_OFS, 16'h1001);
		rd(CTRL_OFS, 16'h1000, 16'hFFFF);
		seq(MASTER | 16'h0001, 16'h0000);
		rxVal = 8'($urandom());
		peer.load(rxVal);
		peer.stretchArm = 1'b1;
		wr(CTRL_OFS, MASTER | 16'h0008);
		rd(CTRL_OFS, MASTER | 16'h0008, 16'hFFFF);
		wr(CTRL_OFS, MASTER | 16'h0001);
		rd(CTRL_OFS, MASTER | 16'h0008, 16'hFFFF);
		waitIdle();
		rd(STAT_OFS, {rxVal, 8'h00}, 16'hFF03);
		rd(CTRL_OFS, MASTER, 16'hFFFF);
		for (int a = 0; a < 2; a++) begin
			wr(CTRL_OFS, MASTER | 16'h0010 | (16'(a) << ACKDATA_BIT));
			for (int k = 0; k < 400 && sclLine !== 1'b1; k++) @(posedge linkClk);
			@(posedge linkClk);
			check(lines() & 16'h0001, 16'(a));
			@(posedge core_clk);
			waitIdle();
			rd(CTRL_OFS, MASTER | (16'(a) << ACKDATA_BIT), 16'hFFFF);
		end
		seq(MASTER | 16'h0002, 16'h0000);
		seq(MASTER | 16'h0004, 16'h0003);
		wr(CTRL_OFS, 16'h9140);
		peer.sendByte(8'($urandom()));
		repeat (40) @(posedge core_clk);
		check(lines() & 16'h0002, 16'h0000);
		rd(CTRL_OFS, 16'h8140, 16'hFFFF);
		rd(STAT_OFS, 16'h0002, 16'h0002);
		wr(CTRL_OFS, 16'h9140);
		repeat (40) @(posedge core_clk);
		check(lines() & 16'h0002, 16'h0002);
		peer.stopBus();
		@(posedge core_clk);
		wr(CTRL_OFS, 16'h9100);
		peer.sendByte(8'($urandom()));
		repeat (40) @(posedge core_clk);
		check(lines() & 16'h0002, 16'h0002);
		peer.stopBus();
		report_and_stop();
	end
endmodule

`default_nettype wire
